// >>> common/flash_host_pkg.sv
// Constants, register map and types for the flash pin-bus controller.
// Assumes a 40 MHz APB clock and a parallel flash on the far side.
package flash_host_pkg;

  // Widths of the flash bus and of the cycle counter.
  localparam int Q_W = 16;
  localparam int A_W = 19;
  localparam int CNT_W = 20;
  typedef logic [CNT_W-1:0] cnt_t;
  typedef logic [Q_W-1:0] qword_t;
  typedef logic [A_W-1:0] faddr_t;

  // Register byte offsets on the APB side.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ADDR = 8'h04;
  localparam logic [7:0] ADDR_WDATA = 8'h08;
  localparam logic [7:0] ADDR_RDATA = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // Control register fields.
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_MSB = 2;
  localparam int CTRL_START = 3;
  localparam int CTRL_TEMP = 4;
  localparam int CTRL_ALLOW = 5;

  // Status register fields.
  localparam int ST_BUSY = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_LOCK = 2;
  localparam int ST_TOGGLING = 3;
  localparam int ST_REJECTED = 4;
  localparam int ST_FAILED = 5;
  localparam int ST_TLIMIT = 6;
  localparam int ST_WINDOW = 7;

  // Reset values of the software-visible fields.
  localparam logic [2:0] OP_RESET_VAL = 3'h0;
  localparam faddr_t ADDR_RESET_VAL = 19'h00000;
  localparam qword_t DATA_RESET_VAL = 16'h0000;

  // Operation codes written into the control register.
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_POLL = 3'h2;
  localparam logic [2:0] OP_ERASE_ADD = 3'h3;
  localparam logic [2:0] OP_PROTECT = 3'h4;
  localparam logic [2:0] OP_UNPROTECT = 3'h5;
  localparam logic [2:0] OP_VERIFY = 3'h6;
  localparam logic [2:0] OP_RESET_CMD = 3'h7;

  // Status bit positions on the flash data bus.
  localparam int QB_PROT = 0;
  localparam int QB_WINDOW = 3;
  localparam int QB_TLIMIT = 5;
  localparam int QB_TOGGLE = 6;

  // Address bit positions used by protection modes, and the reset command word.
  localparam int PROT_QUERY_BIT = 1;
  localparam int PROT_DIR_BIT = 6;
  localparam qword_t RESET_CMD_DATA = 16'h00F0;

  // Timing, each figure in its own unit, then in clock cycles.
  localparam int CLK_NS = 25;
  localparam int T_STROBE_NS = 55;
  localparam int T_ACCESS_NS = 120;
  localparam int T_HIGH_NS = 20;
  localparam int T_HV_SETUP_US = 4;
  localparam int T_PROT_US = 10;
  localparam int T_UNPROT_MS = 12;
  localparam int SYNC_CYC = 4;
  localparam cnt_t CNT_ONE = 20'h00001;
  localparam cnt_t STROBE_CYC = cnt_t'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam cnt_t HIGH_CYC = cnt_t'((T_HIGH_NS + CLK_NS - 1) / CLK_NS);
  localparam cnt_t READ_CYC =
    cnt_t'((T_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC + 1);
  localparam cnt_t HV_SETUP_CYC =
    cnt_t'((T_HV_SETUP_US * 1000 + CLK_NS - 1) / CLK_NS);
  localparam cnt_t PROT_CYC = cnt_t'((T_PROT_US * 1000 + CLK_NS - 1) / CLK_NS);
  localparam int UNPROT_CYC_DEF =
    (T_UNPROT_MS * 1000000 + CLK_NS - 1) / CLK_NS;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_ACT,
    ST_RECOV,
    ST_EVAL
  } seq_state_t;

endpackage : flash_host_pkg

// >>> common/flash_sync_if.sv
// Interface carrying the raw flash data bus into the synchroniser and
// the settled value back out. Only the settled end runs on the APB clock.
interface flash_sync_if;
  logic [15:0] pin_q;
  logic [15:0] q_stable;
  modport sync (input pin_q, output q_stable);
  modport user (output pin_q, input q_stable);
endinterface : flash_sync_if

// >>> verilog/pin_sync3.sv
// Three-stage synchroniser for the flash data bus.
// Assumes the pins change without relation to pclk.
module pin_sync3 (
  input wire logic pclk,
  input wire logic presetn,
  flash_sync_if.sync bus
);
  import flash_host_pkg::*;

  qword_t s1;
  qword_t s2;
  qword_t s3;

  // The settled value follows only once the second and third stages agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= DATA_RESET_VAL;
      s2 <= DATA_RESET_VAL;
      s3 <= DATA_RESET_VAL;
      bus.q_stable <= DATA_RESET_VAL;
    end else begin
      s1 <= bus.pin_q;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        bus.q_stable <= s3;
      end
    end
  end
endmodule : pin_sync3

// >>> verilog/flash_host_ctrl.sv
// Host-side controller that drives a parallel flash through its pins.
// Assumes an APB master on pclk and a flash whose elevated voltages are
// switched by external drivers steered from the enable outputs here.
module flash_host_ctrl #(
  parameter int unprot_cyc = flash_host_pkg::UNPROT_CYC_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output flash_host_pkg::faddr_t flash_addr,
  output flash_host_pkg::qword_t q_out,
  output logic q_oe,
  input wire flash_host_pkg::qword_t q_in,
  output logic elevated_id_voltage_a9,
  output logic elevated_id_voltage_oe,
  output logic elevated_id_voltage_reset,
  output logic flash_reset_n
);
  import flash_host_pkg::*;

  seq_state_t state;
  cnt_t cnt;
  logic [1:0] step;
  logic [2:0] op;
  logic temp_unprotect;
  logic allow_unprotect;
  faddr_t addr_reg;
  qword_t wdata_reg;
  qword_t rdata_reg;
  logic prev_tog;
  logic refused;
  logic fail_lock;
  logic toggling;
  logic erase_rejected;
  logic op_failed;

  flash_sync_if sync_bus ();

  // Pin data enters the clock domain through three stages.
  assign sync_bus.pin_q = q_in;

  pin_sync3 u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .bus(sync_bus.sync)
  );

  // APB decode: the access is answered one cycle after it opens.
  wire access_open = psel & penable & ~pready;
  wire access_done = psel & penable & pready;
  wire sel_ctrl = paddr == ADDR_CTRL;
  wire sel_addr = paddr == ADDR_ADDR;
  wire sel_wdata = paddr == ADDR_WDATA;
  wire sel_rdata = paddr == ADDR_RDATA;
  wire sel_status = paddr == ADDR_STATUS;
  wire sel_hit = sel_ctrl | sel_addr | sel_wdata | sel_rdata | sel_status;
  wire wr_ctrl = access_done & pwrite & sel_ctrl;
  wire wr_addr = access_done & pwrite & sel_addr;
  wire wr_wdata = access_done & pwrite & sel_wdata;
  wire [2:0] new_op = pwdata[CTRL_OP_MSB:CTRL_OP_LSB];
  wire start_req = wr_ctrl & pwdata[CTRL_START];

  // Refusals: after a failure only polling and reset command pass, and
  // chip unprotect needs software to confirm every sector is protected.
  wire lock_block = fail_lock & (new_op != OP_POLL) &
    (new_op != OP_RESET_CMD);
  wire unprot_block = (new_op == OP_UNPROTECT) &
    ~pwdata[CTRL_ALLOW];
  wire start_ok = start_req & (state == ST_IDLE) & ~lock_block &
    ~unprot_block;
  wire start_bad = start_req & ~start_ok;

  // Read multiplexer for the register file.
  wire [7:0] status_bits = {rdata_reg[QB_WINDOW], rdata_reg[QB_TLIMIT],
    op_failed, erase_rejected, toggling, fail_lock, refused,
    state != ST_IDLE};
  wire [31:0] rd_mux =
    sel_ctrl ? {26'h0, allow_unprotect, temp_unprotect, 1'b0, op} :
    sel_addr ? {13'h0, addr_reg} :
    sel_wdata ? {16'h0, wdata_reg} :
    sel_rdata ? {16'h0, rdata_reg} :
    sel_status ? {24'h0, status_bits} : 32'h0;

  // Per-step shape of the pin cycle.
  wire hv_op = (op == OP_PROTECT) | (op == OP_UNPROTECT) |
    (op == OP_VERIFY);
  wire hv_oe_op = (op == OP_PROTECT) | (op == OP_UNPROTECT);
  wire step_write = (op == OP_WRITE) | (op == OP_RESET_CMD) | hv_oe_op |
    ((op == OP_ERASE_ADD) & (step == 2'd1));
  wire cnt_t setup_len = hv_op ? HV_SETUP_CYC : CNT_ONE;
  wire cnt_t recov_len = hv_op ? HV_SETUP_CYC : HIGH_CYC;
  wire cnt_t act_len = (op == OP_PROTECT) ? PROT_CYC :
    (op == OP_UNPROTECT) ? cnt_t'(unprot_cyc) :
    step_write ? STROBE_CYC : READ_CYC;
  wire setup_last = cnt == setup_len - CNT_ONE;
  wire act_last = cnt == act_len - CNT_ONE;
  wire recov_last = cnt == recov_len - CNT_ONE;
  wire pins_active = (state == ST_SETUP) | (state == ST_ACT) |
    (state == ST_RECOV);

  // Address forcing for the protection modes.
  faddr_t pin_addr;
  always_comb begin
    pin_addr = addr_reg;
    if (op == OP_PROTECT) begin
      pin_addr[PROT_DIR_BIT] = 1'b0;
    end else if (op == OP_UNPROTECT) begin
      pin_addr[PROT_DIR_BIT] = 1'b1;
    end else if (op == OP_VERIFY) begin
      pin_addr[PROT_QUERY_BIT] = 1'b1;
    end
  end
  wire qword_t pin_data = (op == OP_RESET_CMD) ? RESET_CMD_DATA : wdata_reg;

  // Status evaluation of the last read.
  wire toggled = rdata_reg[QB_TOGGLE] != prev_tog;
  wire tl_now = rdata_reg[QB_TLIMIT];
  wire win_now = rdata_reg[QB_WINDOW];
  wire poll_more = (step == 2'd0) | (step == 2'd2) |
    ((step == 2'd1) & toggled & tl_now);
  wire erase_more = ((step == 2'd0) & ~win_now) | (step == 2'd1);
  wire more = ((op == OP_POLL) & poll_more) |
    ((op == OP_ERASE_ADD) & erase_more);

  // APB answer path.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= access_open;
      pslverr <= access_open & ~sel_hit;
      if (access_open) begin
        prdata <= rd_mux;
      end
    end
  end

  // Software-written configuration.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op <= OP_RESET_VAL;
      temp_unprotect <= 1'b0;
      allow_unprotect <= 1'b0;
      addr_reg <= ADDR_RESET_VAL;
      wdata_reg <= DATA_RESET_VAL;
    end else begin
      if (wr_ctrl) begin
        temp_unprotect <= pwdata[CTRL_TEMP];
        allow_unprotect <= pwdata[CTRL_ALLOW];
      end
      if (start_ok) begin
        op <= new_op;
      end
      if (wr_addr) begin
        addr_reg <= pwdata[A_W-1:0];
      end
      if (wr_wdata) begin
        wdata_reg <= pwdata[Q_W-1:0];
      end
    end
  end

  // Sequencer: setup, strobe, recovery and evaluation of each step.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      cnt <= '0;
      step <= 2'd0;
    end else begin
      case (state)
        ST_IDLE: begin
          cnt <= '0;
          step <= 2'd0;
          if (start_ok) begin
            state <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          cnt <= setup_last ? '0 : cnt + CNT_ONE;
          if (setup_last) begin
            state <= ST_ACT;
          end
        end
        ST_ACT: begin
          cnt <= act_last ? '0 : cnt + CNT_ONE;
          if (act_last) begin
            state <= ST_RECOV;
          end
        end
        ST_RECOV: begin
          cnt <= recov_last ? '0 : cnt + CNT_ONE;
          if (recov_last) begin
            state <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          step <= step + 2'd1;
          state <= more ? ST_SETUP : ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Read capture: each new sample keeps the previous toggle bit beside it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= DATA_RESET_VAL;
      prev_tog <= 1'b0;
    end else if ((state == ST_ACT) & act_last & ~step_write) begin
      rdata_reg <= sync_bus.q_stable;
      prev_tog <= rdata_reg[QB_TOGGLE];
    end
  end

  // Outcome flags; a new accepted start clears all but fail_lock, refusal sets one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused <= 1'b0;
      fail_lock <= 1'b0;
      toggling <= 1'b0;
      erase_rejected <= 1'b0;
      op_failed <= 1'b0;
    end else begin
      if (start_ok) begin
        refused <= 1'b0;
        erase_rejected <= 1'b0;
        op_failed <= 1'b0;
        toggling <= 1'b0;
      end
      if (start_bad) begin
        refused <= 1'b1;
      end
      if (state == ST_EVAL) begin
        if ((op == OP_POLL) & (step == 2'd1) & toggled & ~tl_now) begin
          toggling <= 1'b1;
        end
        if ((op == OP_POLL) & (step == 2'd3) & toggled) begin
          op_failed <= 1'b1;
          fail_lock <= 1'b1;
        end
        if ((op == OP_ERASE_ADD) & (step != 2'd1) & win_now) begin
          erase_rejected <= 1'b1;
        end
        if (op == OP_RESET_CMD) begin
          fail_lock <= 1'b0;
        end
      end
    end
  end

  // Flash pins, registered one cycle behind the sequencer state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      flash_addr <= ADDR_RESET_VAL;
      q_out <= DATA_RESET_VAL;
      q_oe <= 1'b0;
      elevated_id_voltage_a9 <= 1'b0;
      elevated_id_voltage_oe <= 1'b0;
      elevated_id_voltage_reset <= 1'b0;
      flash_reset_n <= 1'b1;
    end else begin
      ce_n <= ~((state == ST_ACT) | (hv_op & pins_active));
      we_n <= ~((state == ST_ACT) & step_write);
      oe_n <= ~((state == ST_ACT) & ~step_write);
      flash_addr <= pin_addr;
      q_out <= pin_data;
      q_oe <= pins_active & step_write;
      elevated_id_voltage_a9 <= hv_op & pins_active;
      elevated_id_voltage_oe <= hv_oe_op & pins_active;
      elevated_id_voltage_reset <= temp_unprotect;
      flash_reset_n <= 1'b1;
    end
  end

endmodule : flash_host_ctrl

// >>> test/flash_host_ctrl_assertions.sv
// Port checker for the flash pin-bus controller, bound to its top.
// Assumes pclk is the only clock and presetn an async reset.
module flash_host_ctrl_assertions #(
  parameter int unprot_cyc = 50
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire flash_host_pkg::faddr_t flash_addr,
  input wire logic q_oe,
  input wire logic elevated_id_voltage_a9,
  input wire logic elevated_id_voltage_oe
);
  import flash_host_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  int low_cyc;
  // Counts the cycles for which the write strobe has been low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_cyc <= 0;
    else low_cyc <= we_n ? 0 : low_cyc + 1;
  end
  property p_ready_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready late");
  property p_ready_one;
    pready |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready long");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("pslverr alone");
  property p_qual;
    !we_n && !elevated_id_voltage_oe |-> !ce_n && oe_n && q_oe;
  endproperty
  a_qual: assert property (p_qual) else $error("bad write");
  property p_oe_blocks;
    !oe_n && !elevated_id_voltage_oe |-> we_n;
  endproperty
  a_oe_blocks: assert property (p_oe_blocks) else $error("oe");
  property p_strobe;
    $fell(we_n) && !elevated_id_voltage_a9 |-> !we_n [*3] ##1 we_n;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe");
  property p_hv_pins;
    !we_n && elevated_id_voltage_a9 |-> elevated_id_voltage_oe && !ce_n;
  endproperty
  a_hv_pins: assert property (p_hv_pins)
    else $error("hv");
  property p_hv_setup;
    $fell(we_n) && elevated_id_voltage_a9 |-> $past(elevated_id_voltage_oe, 8);
  endproperty
  a_hv_setup: assert property (p_hv_setup) else $error("setup");
  property p_hv_len;
    $rose(we_n) && elevated_id_voltage_a9 |->
      low_cyc == (flash_addr[PROT_DIR_BIT] ? unprot_cyc : int'(PROT_CYC));
  endproperty
  a_hv_len: assert property (p_hv_len)
    else $error("pulse");
  c_prot: cover property ($rose(we_n) && elevated_id_voltage_a9);
  c_write: cover property ($fell(we_n) && !elevated_id_voltage_a9);
  c_err: cover property (pslverr);
endmodule : flash_host_ctrl_assertions

bind flash_host_ctrl flash_host_ctrl_assertions #(.unprot_cyc(unprot_cyc))
  flash_host_ctrl_assertions_inst (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .ce_n, .we_n, .oe_n, .flash_addr, .q_oe, .elevated_id_voltage_a9,
  .elevated_id_voltage_oe);

// >>> test/flash_dev_model.sv
// Behavioural parallel flash on the far side of the controller pins.
// Assumes one word per sector and short command codes.
module flash_dev_model #(
  parameter logic [15:0] ID_CODE = 16'h00C3  // Arbitrary value.
) (
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire flash_host_pkg::faddr_t addr,
  input wire flash_host_pkg::qword_t q_out,
  input wire logic q_oe,
  output flash_host_pkg::qword_t q_in,
  input wire logic hv_sel,
  input wire logic hv_oe,
  input wire logic hv_reset,
  input wire logic stuck,
  input wire logic [7:0] blen
);
  import flash_host_pkg::*;
  qword_t mem [8];
  qword_t rd, last;
  logic [7:0] prot, n;
  logic busy, tlim, tog, arm_p, arm_e;
  wire logic [2:0] sec = addr[18:16];
  wire logic win = n >= 8'h03;
  // Power-up leaves the machine reading the array.
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    {prot, n, busy, tlim, tog, arm_p, arm_e, rd, last} = '0;
  end
  // A write cycle needs select and strobe low with output enable high.
  wire logic wr_cyc = !ce_n && !we_n && oe_n;
  // The write lands as select or strobe rises, whichever comes first, so
  // a select and strobe that rise in one time step cannot race.
  always @(negedge wr_cyc) begin
    if (hv_sel && hv_oe) begin
      if (addr[PROT_DIR_BIT]) prot = '0;
      else prot[sec] = 1'b1;
    end else if (!hv_oe) begin
      if (q_out == RESET_CMD_DATA && (tlim || !busy)) begin
        tlim = 1'b0;
        busy = 1'b0;
      end else if (busy) begin
        if (!win && !tlim && q_out == 16'h0030) mem[sec] = 16'hFFFF;
      end else if (arm_p && (!prot[sec] || hv_reset)) begin
        mem[sec] = q_out;
        last = q_out;
        busy = 1'b1;
        n = '0;
      end else if (arm_e && q_out == 16'h0030) begin
        last = 16'hFFFF;
        busy = 1'b1;
        n = '0;
      end
      arm_p = !busy && q_out == 16'h00A0;
      arm_e = !busy && q_out == 16'h0080;
    end
  end
  // Status words stand in for array data while an operation runs.
  always @(negedge oe_n) begin
    if (hv_sel) begin
      rd = addr[PROT_QUERY_BIT] ? {15'h0, prot[sec]} : ID_CODE;
    end else if (busy) begin
      tog = ~tog;
      rd = {8'h00, ~last[7], tog, tlim, 1'b0, win, 3'h0};
    end else begin
      rd = mem[sec];
    end
  end
  // Each busy read brings the end nearer, or the time-out when stuck.
  always @(posedge oe_n) begin
    if (busy && !hv_sel) n = n + 8'h01;
    if (busy && n >= blen) tlim = stuck;
    if (busy && n >= blen) busy = stuck;
  end
  // A released bus shows the inverse of the last word.
  assign q_in = q_oe ? q_out : (!ce_n && !oe_n ? rd : ~rd);
endmodule : flash_dev_model

// >>> test/tb.sv
// Self-checking bench for the flash pin-bus controller.
// Assumes the behavioural flash model on the far side of the pins.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_host_pkg::*;
  localparam logic [31:0] TMP = 32'h1 << CTRL_TEMP;
  localparam logic [31:0] ALW = 32'h1 << CTRL_ALLOW;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, stuck = 1'b0, e;
  logic [7:0] paddr = 8'h00, blen = 8'h03;
  logic [31:0] pwdata = 32'h0, prdata, r, st;
  logic pready, pslverr, ce_n, we_n, oe_n, q_oe, hv_sel, hv_oe, hv_rst, frst_n;
  faddr_t fa, sa;
  qword_t q_out, q_in;
  int fail_count = 0, checks_done = 0, cyc = 0;
  flash_host_ctrl #(.unprot_cyc(50)) flash_host_ctrl_inst (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ce_n, .we_n, .oe_n, .flash_addr(fa), .q_out, .q_oe, .q_in,
    .elevated_id_voltage_a9(hv_sel), .elevated_id_voltage_oe(hv_oe),
    .elevated_id_voltage_reset(hv_rst), .flash_reset_n(frst_n));
  flash_dev_model flash_dev_model_inst (.ce_n, .we_n, .oe_n, .addr(fa),
    .q_out, .q_oe, .q_in, .hv_sel, .hv_oe, .hv_reset(hv_rst), .stuck, .blen);
  // Clock and a watchdog that cuts a hang short.
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  // One APB transfer; read data and error are taken with pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Starts one flash operation on sector address sa and waits for idle.
  task automatic op(input logic [31:0] c, input qword_t d);
    int i = 0;
    apb(1'b1, ADDR_ADDR, 32'(sa));
    apb(1'b1, ADDR_WDATA, 32'(d));
    apb(1'b1, ADDR_CTRL, c | (32'h1 << CTRL_START));
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      i++;
    end while (r[ST_BUSY] !== 1'b0 && i < 500);
    // A sequencer that never goes idle counts as a mismatch.
    if (r[ST_BUSY] !== 1'b0) begin
      fail_count++;
      $display("MISMATCH op_busy expected 0 seen 1");
    end
    st = r;
    apb(1'b0, ADDR_RDATA, 32'h0);
  endtask : op
  task automatic t_regs();
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status_rst", r, 32'h0);
    apb(1'b1, ADDR_ADDR, 32'hFFFF_FFFF);
    apb(1'b0, ADDR_ADDR, 32'h0);
    chk("addr_width", r, 32'h0007_FFFF);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", {r[30:0], e}, 32'h1);
    $display("done regs");
  endtask : t_regs
  task automatic t_prog();
    sa = 19'h10000;
    op(32'(OP_WRITE), 16'h1234);
    op(32'(OP_READ), 16'h0);
    chk("lone_write", r, 32'h0000_FFFF);
    op(32'(OP_WRITE), 16'h00A0);
    op(32'(OP_WRITE), 16'h1234);
    op(32'(OP_POLL), 16'h0);
    chk("toggling", st & 32'h08, 32'h08);
    chk("poll_bit", r & 32'h80, 32'h80);
    repeat (3) op(32'(OP_POLL), 16'h0);
    chk("settled", st & 32'h08, 32'h0);
    op(32'(OP_READ), 16'h0);
    chk("readback", r, 32'h0000_1234);
    $display("done prog");
  endtask : t_prog
  task automatic t_fail();
    sa = 19'h20000;
    stuck <= 1'b1;
    op(32'(OP_WRITE), 16'h00A0);
    op(32'(OP_WRITE), 16'h0001);
    repeat (2) op(32'(OP_POLL), 16'h0);
    chk("tlim_lock", st & 32'h64, 32'h64);
    op(32'(OP_READ), 16'h0);
    chk("refused", st & 32'h02, 32'h02);
    stuck <= 1'b0;
    op(32'(OP_RESET_CMD), 16'h0);
    chk("unlocked", st & 32'h06, 32'h0);
    op(32'(OP_POLL), 16'h0);
    chk("tlim_clr", st & 32'h40, 32'h0);
    $display("done fail");
  endtask : t_fail
  task automatic t_erase();
    sa = 19'h30000;
    blen <= 8'h08;
    op(32'(OP_WRITE), 16'h0080);
    op(32'(OP_WRITE), 16'h0030);
    sa = 19'h50000;
    op(32'(OP_ERASE_ADD), 16'h0030);
    chk("add_ok", st & 32'h10, 32'h0);
    op(32'(OP_ERASE_ADD), 16'h0030);
    chk("add_late", st & 32'h10, 32'h10);
    repeat (4) op(32'(OP_POLL), 16'h0);
    chk("erase_end", st & 32'h08, 32'h0);
    blen <= 8'h03;
    $display("done erase");
  endtask : t_erase
  task automatic t_prot();
    for (int k = 0; k < 8; k++) begin
      sa = faddr_t'(k << 16);
      op(32'(OP_PROTECT), 16'h0);
    end
    sa = 19'h40000;
    op(32'(OP_VERIFY), 16'h0);
    chk("protected", r, 32'h1);
    op(32'(OP_WRITE), 16'h00A0);
    op(32'(OP_WRITE), 16'h5555);
    op(32'(OP_READ), 16'h0);
    chk("blocked", r, 32'h0000_FFFF);
    op(32'(OP_WRITE) | TMP, 16'h00A0);
    op(32'(OP_WRITE) | TMP, 16'h5555);
    repeat (3) op(32'(OP_POLL) | TMP, 16'h0);
    op(32'(OP_READ), 16'h0);
    chk("temp_open", r, 32'h0000_5555);
    op(32'(OP_UNPROTECT), 16'h0);
    chk("no_allow", st & 32'h02, 32'h02);
    op(32'(OP_UNPROTECT) | ALW, 16'h0);
    for (int k = 0; k < 8; k++) begin
      sa = faddr_t'(k << 16);
      op(32'(OP_VERIFY), 16'h0);
      chk("unprot", r, 32'h0);
    end
    $display("done prot");
  endtask : t_prot
  // Reset for three cycles, then the scenarios in turn.
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_prog();
    t_fail();
    t_erase();
    t_prot();
    final_report();
  end
endmodule : tb
